// >>> rtl/adc_seq_regs.svh
// Purpose: register indices, field positions, channel codes and event bits of the conversion sequencer
// Assumes: byte address on the bus is four times the register index
// Notes: included by its bare name
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

// ****************************************
// register indices
// ****************************************
`define IDX_SC1 14'h0010
`define IDX_SC2 14'h0011
`define IDX_SC3 14'h0012
`define IDX_SC4 14'h0013
`define IDX_RH 14'h0014
`define IDX_RL 14'h0015
`define IDX_CVH 14'h0016
`define IDX_CVL 14'h0017
`define IDX_ISTAT 14'h0018
`define IDX_IMASK 14'h0019
`define IDX_AP1 14'h30ac
`define IDX_AP2 14'h30ad

// ****************************************
// fields and codes
// ****************************************
`define SC1_DONE_IRQ_ENABLE 6
`define SC1_CONTINUOUS_ENABLE 5
`define SC1_CH 4:0
`define SC2_TRG 6
`define SC2_CMPEN 5
`define SC2_CMPGT 4
`define SC4_DEP 2:0
`define SC4_WMASK 8'h67
`define CH_OFF 5'h1f
`define CH_GND 5'h10
`define CH_GND_LAST 5'h13
`define CH_TEMP 5'h16
`define CH_BANDGAP 5'h17
`define CH_HIGH_REF 5'h1d
`define EV_DONE 0
`define EV_OVR 1

`endif

// >>> rtl/adc_seq_pkg.sv
// Purpose: shared types of the conversion sequencer
// Assumes: nothing
// Notes: gray codes along idle, armed, converting
package adc_seq_pkg;
	typedef enum logic [1:0]
	{
		idle = 2'h0,
		armed = 2'h1,
		converting = 2'h3
	} seq_state_e;
endpackage

// >>> rtl/adc_conversion_sequencer.sv
// Purpose: channel select, start, queueing, compare and flags of a SAR converter
// Assumes: classic wishbone slave, one cycle answer; converter pulses conv_done with conv_result
// Notes: result ring pointers wrap at QD, so QD must be a power of two
`timescale 1ns/10ps
`include "adc_seq_regs.svh"

module adc_conversion_sequencer #(
	parameter int QD = 8,
	parameter int RW = 12
)
(
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [15:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// converter and trigger
	input wire logic hw_trigger_input,
	input wire logic conv_done,
	input wire logic [RW-1:0] conv_result,
	output logic conv_start,
	output logic [4:0] channel_select,
	// interrupt
	output logic irq
);

	localparam int PW = $clog2(QD);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		adc_seq_pkg::seq_state_e state;
		logic [4:0] ch;
		logic done_irq_enable;
		logic continuous_enable;
		logic trg;
		logic cmpen;
		logic cmpgt;
		logic done;
		logic [7:0] sc3;
		logic [7:0] sc4;
		logic [7:0] cvh;
		logic [7:0] cvl;
		logic [7:0] ap1;
		logic [7:0] ap2;
		logic [QD-1:0][4:0] chq;
		logic [PW:0] qcnt;
		logic [PW-1:0] cidx;
		logic [QD-1:0][RW-1:0] rq;
		logic [PW-1:0] rwr;
		logic [PW-1:0] rrd;
		logic [PW:0] rcnt;
		logic [RW-1:0] res;
		logic cmp_any;
		logic hw_prev;
		logic [1:0] istat;
		logic [1:0] imask;
		logic irq;
		logic ack;
		logic [31:0] dat;
		logic start;
		logic [4:0] mux;
	} seq_s;

	seq_s st;
	seq_s next_st;

	logic bus_go;
	logic wr_sc1;
	logic rd_low;
	logic fifo_on;
	logic [PW:0] dep;
	logic [RW-1:0] cv;
	logic cmp_ok;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic hit(input logic [15:0] a, input logic [13:0] idx);
		hit = (a[15:2] == idx) && (a[1:0] == 2'h0);
	endfunction

	// reserved codes fall back to ground so the mux never sees an undefined select
	function automatic logic [4:0] mux_code(input logic [4:0] c);
		if (c <= `CH_GND_LAST || c == `CH_TEMP || c == `CH_BANDGAP || c >= `CH_HIGH_REF)
			mux_code = c;
		else
			mux_code = `CH_GND;
	endfunction

	assign bus_go = ce && cyc_i && stb_i && !st.ack;
	assign wr_sc1 = bus_go && we_i && sel_i[0] && hit(adr_i, `IDX_SC1);
	assign rd_low = bus_go && !we_i && hit(adr_i, `IDX_RL);
	assign fifo_on = |st.sc4[`SC4_DEP];
	assign dep = fifo_on ? (PW+1)'(st.sc4[`SC4_DEP]) + (PW+1)'(1) : '0;
	assign cv = RW'({st.cvh, st.cvl});
	assign cmp_ok = !st.cmpen || (st.cmpgt ? (conv_result >= cv) : (conv_result < cv));

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		logic issue;
		logic last;
		logic [7:0] rv;
		logic [RW-1:0] head;
		issue = 1'b0;
		last = 1'b0;
		rv = 8'h00;
		head = fifo_on ? st.rq[st.rrd] : st.res;
		next_st = st;
		next_st.ack = 1'b0;
		next_st.start = 1'b0;
		next_st.hw_prev = hw_trigger_input;

		// bus access
		if (bus_go)
		begin
			next_st.ack = 1'b1;
			if (we_i)
			begin
				if (sel_i[0])
				begin
					if (hit(adr_i, `IDX_SC1))
					begin
						next_st.done = 1'b0;
						next_st.done_irq_enable = dat_i[`SC1_DONE_IRQ_ENABLE];
						next_st.continuous_enable = dat_i[`SC1_CONTINUOUS_ENABLE];
						next_st.ch = dat_i[`SC1_CH];
						if (dat_i[`SC1_CH] == `CH_OFF)
						begin
							next_st.state = adc_seq_pkg::idle;
							next_st.qcnt = '0;
							next_st.rcnt = '0;
							next_st.rwr = '0;
							next_st.rrd = '0;
							next_st.cidx = '0;
						end
						else if (fifo_on)
						begin
							// channels past a full queue are dropped until it is reset
							if (st.qcnt < dep)
							begin
								next_st.chq[st.qcnt[PW-1:0]] = dat_i[`SC1_CH];
								next_st.qcnt = st.qcnt + (PW+1)'(1);
								if (st.qcnt + (PW+1)'(1) == dep)
									issue = 1'b1;
							end
						end
						else
							issue = 1'b1;
						if (issue)
						begin
							next_st.cidx = '0;
							next_st.cmp_any = 1'b0;
							next_st.state = st.trg ? adc_seq_pkg::armed : adc_seq_pkg::converting;
							issue = !st.trg;
						end
					end
					else if (hit(adr_i, `IDX_SC2))
					begin
						next_st.trg = dat_i[`SC2_TRG];
						next_st.cmpen = dat_i[`SC2_CMPEN];
						next_st.cmpgt = dat_i[`SC2_CMPGT];
					end
					else if (hit(adr_i, `IDX_SC3))
						next_st.sc3 = dat_i[7:0];
					else if (hit(adr_i, `IDX_SC4))
						next_st.sc4 = dat_i[7:0] & `SC4_WMASK;
					else if (hit(adr_i, `IDX_CVH))
						next_st.cvh = dat_i[7:0];
					else if (hit(adr_i, `IDX_CVL))
						next_st.cvl = dat_i[7:0];
					else if (hit(adr_i, `IDX_IMASK))
						next_st.imask = dat_i[1:0];
					else if (hit(adr_i, `IDX_AP1))
						next_st.ap1 = dat_i[7:0];
					else if (hit(adr_i, `IDX_AP2))
						next_st.ap2 = dat_i[7:0];
				end
				next_st.dat = '0;
			end
			else
			begin
				if (hit(adr_i, `IDX_SC1))
					rv = {st.done, st.done_irq_enable, st.continuous_enable, st.ch};
				else if (hit(adr_i, `IDX_SC2))
					rv = {st.state == adc_seq_pkg::converting, st.trg, st.cmpen, st.cmpgt,
						st.rcnt == '0, fifo_on && st.rcnt >= dep, 2'h0};
				else if (hit(adr_i, `IDX_SC3))
					rv = st.sc3;
				else if (hit(adr_i, `IDX_SC4))
					rv = st.sc4;
				else if (hit(adr_i, `IDX_RH))
					rv = 8'(head >> 8);
				else if (hit(adr_i, `IDX_RL))
				begin
					rv = head[7:0];
					next_st.done = 1'b0;
					if (st.rcnt != '0)
					begin
						next_st.rcnt = st.rcnt - (PW+1)'(1);
						if (fifo_on)
							next_st.rrd = st.rrd + PW'(1);
					end
				end
				else if (hit(adr_i, `IDX_CVH))
					rv = st.cvh;
				else if (hit(adr_i, `IDX_CVL))
					rv = st.cvl;
				else if (hit(adr_i, `IDX_ISTAT))
				begin
					rv = {6'h00, st.istat};
					next_st.istat = 2'h0;
				end
				else if (hit(adr_i, `IDX_IMASK))
					rv = {6'h00, st.imask};
				else if (hit(adr_i, `IDX_AP1))
					rv = st.ap1;
				else if (hit(adr_i, `IDX_AP2))
					rv = st.ap2;
				next_st.dat = {24'h000000, rv};
			end
		end

		// conversion engine; a completion before the converter saw the latest start belongs to the old run
		if (ce && !wr_sc1)
		begin
			unique case (st.state)
				adc_seq_pkg::idle:
				begin
				end
				adc_seq_pkg::armed:
				begin
					if (hw_trigger_input && !st.hw_prev)
					begin
						next_st.state = adc_seq_pkg::converting;
						issue = 1'b1;
					end
				end
				adc_seq_pkg::converting:
				begin
					if (conv_done && !st.start)
					begin
						if (!fifo_on)
						begin
							last = 1'b1;
							if (cmp_ok)
							begin
								next_st.res = conv_result;
								next_st.rcnt = (PW+1)'(1);
								next_st.done = 1'b1;
								next_st.istat[`EV_DONE] = 1'b1;
							end
						end
						else
						begin
							next_st.rq[st.rwr] = conv_result;
							next_st.rwr = st.rwr + PW'(1);
							// a full ring loses its oldest entry
							if (next_st.rcnt >= dep)
							begin
								next_st.rrd = next_st.rrd + PW'(1);
								next_st.istat[`EV_OVR] = 1'b1;
							end
							else
								next_st.rcnt = next_st.rcnt + (PW+1)'(1);
							next_st.cmp_any = st.cmp_any | cmp_ok;
							if ((PW+1)'(st.cidx) == dep - (PW+1)'(1))
							begin
								last = 1'b1;
								next_st.cidx = '0;
								next_st.cmp_any = 1'b0;
								if (st.cmp_any || cmp_ok)
								begin
									next_st.done = 1'b1;
									next_st.istat[`EV_DONE] = 1'b1;
								end
							end
							else
							begin
								next_st.cidx = st.cidx + PW'(1);
								issue = 1'b1;
							end
						end
						if (last)
						begin
							if (st.continuous_enable)
								issue = 1'b1;
							else
								next_st.state = adc_seq_pkg::idle;
						end
					end
				end
			endcase
		end

		if (issue)
		begin
			next_st.start = 1'b1;
			next_st.mux = mux_code(fifo_on ? next_st.chq[next_st.cidx] : next_st.ch);
		end
		next_st.irq = (next_st.done && next_st.done_irq_enable) || |(next_st.istat & next_st.imask);
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st <= '0;
			st.ch <= `CH_OFF;
		end
		else if (ce)
			st <= next_st;
	end

	assign dat_o = st.dat;
	assign ack_o = st.ack;
	assign conv_start = st.start;
	assign channel_select = st.mux;
	assign irq = st.irq;

	// ****************************************
	// assertions
	// ****************************************
	AST_ABORT_START: assert property (@(posedge core_clk) disable iff (!rst_n)
		(wr_sc1 && dat_i[4:0] != `CH_OFF && !fifo_on && !st.trg)
		|=> (st.state == adc_seq_pkg::converting && st.start && !st.done))
		else $error("control write did not restart conversion");

	AST_FIFO_WAIT: assert property (@(posedge core_clk) disable iff (!rst_n)
		(wr_sc1 && fifo_on && dat_i[4:0] != `CH_OFF && st.state == adc_seq_pkg::idle
		&& st.qcnt + (PW+1)'(1) < dep) |=> (st.state == adc_seq_pkg::idle && !st.start))
		else $error("queue started before reaching depth");

	AST_DISABLE_HALT: assert property (@(posedge core_clk) disable iff (!rst_n)
		(wr_sc1 && dat_i[4:0] == `CH_OFF)
		|=> (st.state == adc_seq_pkg::idle && st.qcnt == '0 && st.rcnt == '0))
		else $error("disable code did not clear and halt");

	AST_DONE_PLAIN: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ce && !wr_sc1 && st.state == adc_seq_pkg::converting && conv_done && !st.start
		&& !fifo_on && !st.cmpen)
		|=> (st.done && st.res == $past(conv_result)))
		else $error("finished conversion did not set done");

	AST_CMP_FALSE: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ce && !wr_sc1 && !rd_low && st.state == adc_seq_pkg::converting && conv_done
		&& !st.start && !fifo_on && st.cmpen && !cmp_ok) |=> (st.done == $past(st.done)))
		else $error("failed compare changed done");

	AST_LOW_CLEARS: assert property (@(posedge core_clk) disable iff (!rst_n)
		(rd_low && !(st.state == adc_seq_pkg::converting && conv_done)) |=> !st.done)
		else $error("low result read did not clear done");

	AST_IRQ: assert property (@(posedge core_clk) disable iff (!rst_n)
		(st.done && st.done_irq_enable) |-> irq)
		else $error("done with enable but no interrupt");

	AST_SINGLE_STOP: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ce && !wr_sc1 && st.state == adc_seq_pkg::converting && conv_done && !st.start
		&& !fifo_on && !st.continuous_enable)
		|=> (st.state == adc_seq_pkg::idle && !st.start))
		else $error("single conversion did not stop");

	AST_CONT_RESTART: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ce && !wr_sc1 && st.state == adc_seq_pkg::converting && conv_done && !st.start
		&& !fifo_on && st.continuous_enable)
		|=> (st.start && st.state == adc_seq_pkg::converting))
		else $error("continuous conversion did not restart");

	AST_HW_START: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ce && !wr_sc1 && st.state == adc_seq_pkg::armed && hw_trigger_input && !st.hw_prev)
		|=> (st.start && st.state == adc_seq_pkg::converting))
		else $error("hardware trigger edge did not start");

	AST_CE_FREEZE: assert property (@(posedge core_clk) disable iff (!rst_n)
		!ce |=> $stable(st))
		else $error("state changed while clock enable low");

endmodule

// >>> dv/sar_converter_model.sv
// Purpose: converter far side of the sequencer
// Assumes: one conversion outstanding; a new start restarts it
// Notes: result carries the channel so the bench can predict it
`timescale 1ns/10ps
module sar_converter_model #(
	parameter int LAT = 4
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// sequencer side
	input wire logic conv_start,
	input wire logic [4:0] channel_select,
	output logic conv_done,
	output logic [11:0] conv_result
);
	int cnt;
	logic [4:0] ch;
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= 0;
			ch <= 5'h0;
			conv_done <= 1'b0;
			conv_result <= 12'h0;
		end
		else if (conv_start)
		begin
			cnt <= LAT;
			ch <= channel_select;
			conv_done <= 1'b0;
			conv_result <= ~conv_result;
		end
		else if (cnt == 1)
		begin
			cnt <= 0;
			conv_done <= 1'b1;
			conv_result <= {7'h2b, ch};
		end
		else
		begin
			cnt <= (cnt != 0) ? cnt - 1 : 0;
			conv_done <= 1'b0;
			// result is not held outside the done pulse
			conv_result <= ~conv_result;
		end
	end
endmodule

// >>> dv/testbench.sv
// Purpose: self-checking bench of the conversion sequencer
// Assumes: one cycle wishbone answer, model latency 4
// Notes: expected results come from the channel code only; compare checks also use the compare value
`timescale 1ns/10ps
`include "adc_seq_regs.svh"
module testbench;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [15:0] adr = 16'h0;
	logic [7:0] dat = 8'h0;
	logic hw = 1'b0;
	logic ce = 1'b1;
	logic [31:0] dat_o;
	logic ack_o;
	logic conv_done;
	logic [11:0] conv_result;
	logic conv_start;
	logic [4:0] channel_select;
	logic irq;
	logic [31:0] r;
	logic [31:0] rs = 32'haebc;
	logic [11:0] cv;
	logic [4:0] ch;
	logic f;
	logic gt;
	int miscompares = 0;
	int compares = 0;
	logic [13:0] ridx [11] = '{14'h10, 14'h11, 14'h12, 14'h13, 14'h14, 14'h15, 14'h16, 14'h17, 14'h30ac,
		14'h30ad, 14'h20};
	logic [7:0] rval [11] = '{8'h1f, 8'h08, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0};
	logic [4:0] codes [10] = '{5'h00, 5'h0f, 5'h10, 5'h13, 5'h14, 5'h16, 5'h17, 5'h18, 5'h1d, 5'h1e};

	adc_conversion_sequencer dut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i({24'h0, dat}), .dat_o(dat_o), .ack_o(ack_o),
		.hw_trigger_input(hw), .conv_done(conv_done), .conv_result(conv_result), .conv_start(conv_start),
		.channel_select(channel_select), .irq(irq));
	sar_converter_model model (.core_clk(core_clk), .rst_n(rst_n), .conv_start(conv_start),
		.channel_select(channel_select), .conv_done(conv_done), .conv_result(conv_result));

	// ****************************************
	// helpers
	// ****************************************
	function logic [31:0] xr();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	// reserved codes are converted as ground
	function automatic logic [4:0] mux_of(input logic [4:0] c);
		return (c == 5'h14 || c == 5'h15 || (c >= 5'h18 && c <= 5'h1c)) ? 5'h10 : c;
	endfunction
	task automatic conclude();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [13:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		dat <= d;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (ack_o !== 1'b1 && n < 20);
		r = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 20)
		begin
			miscompares++;
			$display("mismatch at %0t: no bus answer", $time);
			conclude();
		end
	endtask
	task automatic rdc(input logic [13:0] idx, input logic [7:0] m, input logic [7:0] e);
		wb(1'b0, idx, 8'h0);
		chk(r & {24'h0, m}, {24'h0, e});
	endtask
	task automatic wait_done(output logic got);
		got = 1'b0;
		for (int i = 0; i < 30 && got !== 1'b1; i++)
		begin
			wb(1'b0, `IDX_SC1, 8'h0);
			got = r[7];
		end
	endtask

	initial
	begin
		forever #2 core_clk = ~core_clk;
	end

	// ****************************************
	// scenarios
	// ****************************************
	initial
	begin
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 11; i++)
			rdc(ridx[i], 8'hff, rval[i]);
		wb(1'b1, `IDX_SC2, 8'h8c);
		wb(1'b1, `IDX_RL, 8'hff);
		rdc(`IDX_SC2, 8'hff, 8'h08);
		rdc(`IDX_RL, 8'hff, 8'h00);
		for (int i = 0; i < 10; i++)
		begin
			wb(1'b1, `IDX_SC1, {3'h0, codes[i]});
			rdc(`IDX_SC2, 8'h88, 8'h88);
			wait_done(f);
			chk(f, 1);
			chk(channel_select, mux_of(codes[i]));
			rdc(`IDX_SC2, 8'h88, 8'h00);
			rdc(`IDX_RH, 8'hff, 8'h05);
			rdc(`IDX_RL, 8'hff, {3'h3, mux_of(codes[i])});
			rdc(`IDX_SC1, 8'h80, 8'h00);
			rdc(`IDX_SC2, 8'h08, 8'h08);
		end
		wb(1'b1, `IDX_SC1, 8'h03);
		wb(1'b1, `IDX_SC1, 8'h09);
		wait_done(f);
		rdc(`IDX_RL, 8'hff, 8'h69);
		wb(1'b1, `IDX_SC1, 8'h05);
		wb(1'b1, `IDX_SC1, 8'h1f);
		rdc(`IDX_SC2, 8'h80, 8'h00);
		wait_done(f);
		chk(f, 0);
		for (int i = 0; i < 6; i++)
		begin
			ch = xr() % 16;
			cv = (i < 2) ? {7'h2b, ch} : xr();
			gt = (i < 2) ? i[0] : xr() & 1;
			wb(1'b1, `IDX_CVH, {4'h0, cv[11:8]});
			wb(1'b1, `IDX_CVL, cv[7:0]);
			wb(1'b1, `IDX_SC2, {2'b00, 1'b1, gt, 4'h0});
			wb(1'b1, `IDX_SC1, {3'h0, ch});
			wait_done(f);
			chk(f, gt ? ({7'h2b, ch} >= cv) : ({7'h2b, ch} < cv));
		end
		wb(1'b1, `IDX_SC2, 8'h40);
		wb(1'b1, `IDX_SC1, 8'h07);
		rdc(`IDX_SC2, 8'h80, 8'h00);
		// a trigger pulse while frozen is never seen by the edge detector
		ce <= 1'b0;
		hw <= 1'b1;
		repeat (3) @(posedge core_clk);
		hw <= 1'b0;
		ce <= 1'b1;
		rdc(`IDX_SC2, 8'h80, 8'h00);
		hw <= 1'b1;
		repeat (3) @(posedge core_clk);
		hw <= 1'b0;
		wait_done(f);
		chk(f, 1);
		rdc(`IDX_RL, 8'hff, 8'h67);
		wait_done(f);
		chk(f, 0);
		wb(1'b1, `IDX_SC2, 8'h00);
		wb(1'b1, `IDX_SC1, 8'h22);
		wait_done(f);
		wb(1'b0, `IDX_RL, 8'h0);
		wait_done(f);
		chk(f, 1);
		wb(1'b1, `IDX_SC1, 8'h1f);
		wb(1'b1, `IDX_IMASK, 8'h01);
		rdc(`IDX_ISTAT, 8'h01, 8'h01);
		chk(irq, 0);
		wb(1'b1, `IDX_SC1, 8'h04);
		wait_done(f);
		repeat (2) @(posedge core_clk);
		chk(irq, 1);
		rdc(`IDX_ISTAT, 8'h01, 8'h01);
		repeat (2) @(posedge core_clk);
		chk(irq, 0);
		wb(1'b1, `IDX_IMASK, 8'h00);
		wb(1'b1, `IDX_SC1, 8'h44);
		wait_done(f);
		repeat (2) @(posedge core_clk);
		chk(irq, 1);
		wb(1'b0, `IDX_RL, 8'h0);
		repeat (2) @(posedge core_clk);
		chk(irq, 0);
		wb(1'b1, `IDX_SC4, 8'h01);
		wb(1'b1, `IDX_SC1, 8'h0a);
		repeat (8) @(posedge core_clk);
		rdc(`IDX_SC2, 8'h80, 8'h00);
		wb(1'b1, `IDX_SC1, 8'h02);
		wait_done(f);
		chk(f, 1);
		rdc(`IDX_SC2, 8'h0c, 8'h04);
		rdc(`IDX_RL, 8'hff, 8'h6a);
		rdc(`IDX_RL, 8'hff, 8'h62);
		rdc(`IDX_SC2, 8'h0c, 8'h08);
		wb(1'b1, `IDX_SC1, 8'h1f);
		conclude();
	end
endmodule
